// ---- core/supply_reset_watchdog.sv ----
`default_nettype none

module supply_reset_watchdog
	import supervisor_pkg::*;
#(
	parameter supervisor_pkg::cnt_type HOLD_CYCLES    = supervisor_pkg::HOLD_CYCLES_DEF,
	parameter supervisor_pkg::cnt_type TIMEOUT_CYCLES = supervisor_pkg::TIMEOUT_CYCLES_DEF
) (
	input  wire logic SYS_CLK_IN,
	input  wire logic RST_IN,
	input  wire logic SUPPLY_FAIL_IN,
	input  wire logic WATCHDOG_SERVICE_LINE_IN,
	input  wire logic WATCHDOG_MID_LEVEL_IN,
	output var  logic RESET_N_OUT,
	output var  logic RESET_OUT,
	output var  logic WATCHDOG_FAULT_N_OUT
);

	import supervisor_pkg::*;

	sup_state_type s_q;
	sup_state_type s_d;
	wd_in_type     wd_in;
	wd_event_type  evt;
	logic          hold_done;

	// ==========================================
	// Watchdog timer
	assign wd_in.level = WATCHDOG_SERVICE_LINE_IN;
	assign wd_in.mid   = WATCHDOG_MID_LEVEL_IN;

	wdog_timer #(
		.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
	) u_timer (
		.clk_in         (SYS_CLK_IN),
		.rst_in         (RST_IN),
		.wd_in          (wd_in),
		.supply_fail_in (SUPPLY_FAIL_IN),
		.evt_out        (evt)
	);

	// ==========================================
	// Reset sequencer
	// Supply hold counts from the first clear edge, so it ends a full hold later
	assign hold_done = (s_q.cnt == HOLD_CYCLES); // see R2

	always_comb begin
		s_d = s_q;
		case (s_q.mode)
			ST_RUN: begin
				if (evt.expire) begin
					s_d.mode = ST_PULSE; // see R3
					// Entry edge is the first low cycle, so the pulse is exactly a hold
					s_d.cnt  = CNT_ONE;
				end
			end
			ST_HOLD,
			ST_PULSE: begin
				// Same monostable serves supply and watchdog, see R15
				if (hold_done) begin
					s_d.mode = ST_RUN;
					s_d.cnt  = CNT_ZERO;
				end else begin
					s_d.cnt = cnt_type'(s_q.cnt + CNT_ONE);
				end
			end
			default: begin
				s_d.mode = ST_HOLD;
				s_d.cnt  = CNT_ZERO;
			end
		endcase
		// Supply failure overrides everything and restarts the hold
		if (SUPPLY_FAIL_IN) begin
			s_d.mode = ST_HOLD; // see R1
			s_d.cnt  = CNT_ZERO; // see R2
		end
		s_d.reset_n = (s_d.mode == ST_RUN);
		s_d.reset   = ~s_d.reset_n; // see R11
		// Fault flag: release wins over a coincident expiry
		if (SUPPLY_FAIL_IN) begin
			s_d.fault_n = 1'b1; // see R10
		end else if (WATCHDOG_MID_LEVEL_IN) begin
			s_d.fault_n = 1'b1; // see R7
		end else if (evt.service) begin
			s_d.fault_n = 1'b1; // see R9
		end else if (evt.expire) begin
			s_d.fault_n = 1'b0; // see R8
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			s_q.mode    <= ST_HOLD;
			s_q.cnt     <= CNT_ZERO;
			s_q.reset_n <= RESET_N_RST;
			s_q.reset   <= ~RESET_N_RST;
			s_q.fault_n <= FAULT_N_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign RESET_N_OUT          = s_q.reset_n;
	assign RESET_OUT            = s_q.reset;
	assign WATCHDOG_FAULT_N_OUT = s_q.fault_n;

	// ==========================================
	// Helper logic for checks
	// Length of the current low stretch of the reset output
	cnt_type low_run_q;
	// Cycles since the last watchdog expiry, service edge, supply failure or mid level, saturating
	cnt_type since_exp_q;
	logic    seen_exp_q;

	always_ff @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			low_run_q   <= CNT_ZERO;
			since_exp_q <= CNT_ZERO;
			seen_exp_q  <= 1'b0;
		end else begin
			if (RESET_N_OUT) begin
				low_run_q <= CNT_ZERO;
			end else if (low_run_q != '1) begin
				low_run_q <= cnt_type'(low_run_q + CNT_ONE);
			end
			if (evt.expire || evt.service || SUPPLY_FAIL_IN
				|| WATCHDOG_MID_LEVEL_IN) begin
				since_exp_q <= CNT_ZERO;
				seen_exp_q  <= evt.expire;
			end else if (since_exp_q != '1) begin
				since_exp_q <= cnt_type'(since_exp_q + CNT_ONE);
			end
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);

	property p_supply_low;
		SUPPLY_FAIL_IN |=> !RESET_N_OUT && RESET_OUT;
	endproperty
	a_supply_low: assert property (p_supply_low) // see R1
		else $error("reset not asserted during supply failure");

	property p_hold_min;
		$rose(RESET_N_OUT) |-> (low_run_q >= HOLD_CYCLES);
	endproperty
	a_hold_min: assert property (p_hold_min) // see R2
		else $error("reset released before the hold time");

	property p_hold_restart;
		(SUPPLY_FAIL_IN && !RESET_N_OUT)
			|=> (s_q.cnt == CNT_ZERO) ##1 !RESET_N_OUT [*4];
	endproperty
	a_hold_restart: assert property (p_hold_restart) // see R2
		else $error("supply failure did not restart the hold");

	property p_expire_pulse;
		(evt.expire && RESET_N_OUT && !SUPPLY_FAIL_IN)
			|=> !RESET_N_OUT && s_q.mode == ST_PULSE;
	endproperty
	a_expire_pulse: assert property (p_expire_pulse) // see R3
		else $error("watchdog expiry did not start a reset pulse");

	property p_pulse_exact;
		$rose(RESET_N_OUT) && $past(s_q.mode) == ST_PULSE
			|-> low_run_q == HOLD_CYCLES;
	endproperty
	a_pulse_exact: assert property (p_pulse_exact) // see R3
		else $error("watchdog pulse length wrong");

	property p_repeat;
		(evt.expire && seen_exp_q) |-> since_exp_q == cnt_type'(TIMEOUT_CYCLES - CNT_ONE);
	endproperty
	a_repeat: assert property (p_repeat) // see R6
		else $error("stuck line expiry period wrong");

	property p_complement;
		RESET_OUT == !RESET_N_OUT;
	endproperty
	a_complement: assert property (p_complement) // see R11
		else $error("reset outputs not complementary");

	property p_fault_low;
		(evt.expire && !evt.service && !SUPPLY_FAIL_IN && !WATCHDOG_MID_LEVEL_IN)
			|=> !WATCHDOG_FAULT_N_OUT;
	endproperty
	a_fault_low: assert property (p_fault_low) // see R8
		else $error("fault not signalled on expiry");

	property p_fault_clear;
		evt.service |=> WATCHDOG_FAULT_N_OUT;
	endproperty
	a_fault_clear: assert property (p_fault_clear) // see R9
		else $error("fault not cleared by a service edge");

	property p_fault_supply;
		SUPPLY_FAIL_IN |=> WATCHDOG_FAULT_N_OUT;
	endproperty
	a_fault_supply: assert property (p_fault_supply) // see R10
		else $error("fault low during supply failure");

	property p_mid_disable;
		WATCHDOG_MID_LEVEL_IN [*2] |=> WATCHDOG_FAULT_N_OUT && !evt.expire;
	endproperty
	a_mid_disable: assert property (p_mid_disable) // see R7
		else $error("watchdog active while disabled");

	property p_mid_no_pulse;
		(WATCHDOG_MID_LEVEL_IN [*2] ##0 RESET_N_OUT && !SUPPLY_FAIL_IN)
			|=> RESET_N_OUT;
	endproperty
	a_mid_no_pulse: assert property (p_mid_no_pulse) // see R7
		else $error("reset pulse while watchdog disabled");

	c_supply_release: cover property (
		!RESET_N_OUT && !SUPPLY_FAIL_IN ##1 $rose(RESET_N_OUT));
	c_wdog_pulse: cover property (
		RESET_N_OUT && evt.expire ##1 !RESET_N_OUT);
	c_service: cover property (
		!WATCHDOG_FAULT_N_OUT ##1 evt.service ##1 WATCHDOG_FAULT_N_OUT);
	c_repeat: cover property (evt.expire && seen_exp_q);

endmodule

`default_nettype wire

// ---- core/supervisor_pkg.sv ----
// Function
// R1 - Reset output held low while the supply-fail indication is present.
// R2 - Reset held at least 140 ms after supply recovers; new failure restarts hold.
// R3 - Watchdog timeout while enabled pulses reset low for at least 140 ms.
// R4 - Every service line transition restarts the timeout count from zero.
// R5 - Rising and falling service line transitions both count as service.
// R6 - A stuck service line repeats a reset pulse once per timeout period.
// R7 - Mid-level service line disables watchdog resets and keeps fault high.
// R8 - Fault output goes low when the service line misses the timeout.
// R9 - Fault output returns high on the next service line transition.
// R10 - Fault output forced high while the supply-fail indication is present.
// R11 - Active-high reset output is always the complement of the low one.
// R12 - Processor toggles the service line at least every 1.6 seconds.
// R13 - Systems without a watchdog leave the service line undriven.
// R14 - Timeout period lies between 1.0 s and 2.25 s, typically 1.6 s.
// R15 - Hold and timeout come from internal clock counts set by parameters.
// R16 - Service line is a digital level plus a mid-level detect that disables.
`default_nettype none

package supervisor_pkg;

	// ==========================================
	// Timing
	localparam int CLK_KHZ         = 40_000;
	localparam int HOLD_TIME_MS    = 140;
	localparam int TIMEOUT_TIME_MS = 1600; // see R14
	localparam int CNT_W           = 27;

	typedef logic [CNT_W-1:0] cnt_type;

	function automatic cnt_type ms_to_cycles(input int ms);
		ms_to_cycles = cnt_type'(ms * CLK_KHZ);
	endfunction

	localparam cnt_type HOLD_CYCLES_DEF    = ms_to_cycles(HOLD_TIME_MS);
	localparam cnt_type TIMEOUT_CYCLES_DEF = ms_to_cycles(TIMEOUT_TIME_MS);
	localparam cnt_type CNT_ZERO           = 27'h0000000;
	localparam cnt_type CNT_ONE            = 27'h0000001;

	// ==========================================
	// Reset values
	localparam logic RESET_N_RST = 1'b0;
	localparam logic FAULT_N_RST = 1'b1;

	// ==========================================
	// Types
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_PULSE,
		ST_RUN
	} sup_mode_type;

	typedef struct packed {
		logic level;
		logic mid;
	} wd_in_type;

	typedef struct packed {
		logic expire;
		logic service;
	} wd_event_type;

	typedef struct packed {
		logic    level_q;
		cnt_type cnt;
		logic    expire;
		logic    service;
	} timer_state_type;

	typedef struct packed {
		sup_mode_type mode;
		cnt_type      cnt;
		logic         reset_n;
		logic         reset;
		logic         fault_n;
	} sup_state_type;

endpackage

`default_nettype wire

// ---- core/wdog_timer.sv ----
`default_nettype none

module wdog_timer
	import supervisor_pkg::*;
#(
	parameter supervisor_pkg::cnt_type TIMEOUT_CYCLES = supervisor_pkg::TIMEOUT_CYCLES_DEF
) (
	input  wire logic                     clk_in,
	input  wire logic                     rst_in,
	input  wire supervisor_pkg::wd_in_type wd_in,
	input  wire logic                     supply_fail_in,
	output var supervisor_pkg::wd_event_type evt_out
);

	timer_state_type s_q;
	timer_state_type s_d;

	// ==========================================
	// Timeout counter
	always_comb begin
		s_d         = s_q;
		s_d.level_q = wd_in.level;
		s_d.expire  = 1'b0;
		s_d.service = 1'b0;
		if (wd_in.mid || supply_fail_in) begin
			s_d.cnt = CNT_ZERO; // see R16
		end else if (wd_in.level != s_q.level_q) begin
			s_d.cnt     = CNT_ZERO; // see R4
			s_d.service = 1'b1; // see R5
		end else if (s_q.cnt == cnt_type'(TIMEOUT_CYCLES - CNT_ONE)) begin
			// Wraps so a stuck line keeps firing, see R6
			s_d.cnt    = CNT_ZERO;
			s_d.expire = 1'b1; // see R15
		end else begin
			s_d.cnt = cnt_type'(s_q.cnt + CNT_ONE);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign evt_out.expire  = s_q.expire;
	assign evt_out.service = s_q.service;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_edge_restart;
		(!wd_in.mid && !supply_fail_in && $changed(wd_in.level))
			|=> (s_q.cnt == CNT_ZERO) && evt_out.service;
	endproperty
	a_edge_restart: assert property (p_edge_restart) // see R4
		else $error("service edge did not restart the count");

	property p_fall_service;
		(!wd_in.mid && !supply_fail_in && $fell(wd_in.level))
			|=> evt_out.service ##1 !evt_out.service;
	endproperty
	a_fall_service: assert property (p_fall_service) // see R5
		else $error("falling edge not taken as service");

	property p_expire_at_end;
		(!wd_in.mid && !supply_fail_in && !$changed(wd_in.level)
			&& s_q.cnt == cnt_type'(TIMEOUT_CYCLES - CNT_ONE))
			|=> evt_out.expire && s_q.cnt == CNT_ZERO;
	endproperty
	a_expire_at_end: assert property (p_expire_at_end) // see R6
		else $error("timeout did not expire at full count");

	property p_mid_quiet;
		wd_in.mid |=> !evt_out.expire && !evt_out.service;
	endproperty
	a_mid_quiet: assert property (p_mid_quiet) // see R16
		else $error("watchdog active at mid level");

endmodule

`default_nettype wire

// ---- tb/cpu_model.sv ----
`default_nettype none

module cpu_model (
	input  wire logic       clk_in,
	input  wire logic       float_in,
	input  wire logic [7:0] period_in,
	input  wire logic       kick_in,
	output var  logic       line_out,
	output var  logic       mid_out
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] cnt_q = 8'h00;
	logic       lvl_q = 1'b0;

	initial begin
		line_out = 1'b0;
		mid_out = 1'b1;
	end

	// ==========================================
	// Service line
	always @(posedge clk_in) begin
		mid_out <= float_in;
		cnt_q <= cnt_q + 8'h01;
		if (float_in) begin
			// Floating pin has no defined level, so it wanders every cycle
			line_out <= ~line_out;
		end else if (kick_in || (period_in != 8'h00 && cnt_q >= period_in)) begin
			cnt_q <= 8'h00;
			lvl_q <= ~lvl_q;
			line_out <= ~lvl_q;
		end else begin
			line_out <= lvl_q;
		end
	end
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none

module tb;
	import supervisor_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int H = 16;
	localparam int T = 64;

	typedef struct {
		int len1;
		int gap;
		int len2;
		int low;
	} row_type;

	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       fail = 1'b0;
	logic       flt = 1'b1;
	logic [7:0] per = 8'h00;
	logic       kick = 1'b0;
	logic       line;
	logic       mid;
	logic       rst_n_o;
	logic       rst_o;
	logic       fault_n;
	int         n_errors = 0;
	int         n_compared = 0;
	int         lowcnt = 0;
	int         fcnt = 0;
	row_type    rows [4] = '{'{1, 0, 0, 1 + H}, '{2, 0, 0, 2 + H},
		'{30, 0, 0, 30 + H}, '{3, 8, 2, 13 + H}};

	supply_reset_watchdog #(
		.HOLD_CYCLES   (27'h0000010),
		.TIMEOUT_CYCLES(27'h0000040)
	) DUT (
		.SYS_CLK_IN              (clk),
		.RST_IN                  (rst),
		.SUPPLY_FAIL_IN          (fail),
		.WATCHDOG_SERVICE_LINE_IN(line),
		.WATCHDOG_MID_LEVEL_IN   (mid),
		.RESET_N_OUT             (rst_n_o),
		.RESET_OUT               (rst_o),
		.WATCHDOG_FAULT_N_OUT    (fault_n)
	);

	cpu_model partner (
		.clk_in   (clk),
		.float_in (flt),
		.period_in(per),
		.kick_in  (kick),
		.line_out (line),
		.mid_out  (mid)
	);

	initial begin
		forever #12.5 clk = ~clk;
	end

	// ==========================================
	// Checking
	task automatic report_and_stop();
		if (n_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %0b seen %0b", what, exp, got);
		end
	endtask

	task automatic cmp_int(input string what, input int exp, input int got);
		n_compared++;
		if (got != exp) begin
			n_errors++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic wait_low(input logic sel);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			#1;
			if ((sel ? fault_n : rst_n_o) === 1'b0) break;
		end
		if (i == 300) begin
			n_errors++;
			report_and_stop();
		end
	endtask

	// Counters sample settled outputs; main zeroes them on the edge only
	always @(posedge clk) begin
		#1;
		if (rst_n_o !== 1'b1) lowcnt++;
		if (fault_n !== 1'b1) fcnt++;
		if (!rst) cmp("active high reset", ~rst_n_o, rst_o);
	end

	// ==========================================
	// Sequence
	initial begin
		repeat (10) @(posedge clk);
		#1;
		cmp("reset low in reset", 1'b0, rst_n_o);
		cmp("fault in reset", 1'b1, fault_n);
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		lowcnt = 0;
		repeat (40) @(posedge clk);
		cmp_int("power-up hold", H + 1, lowcnt);
		foreach (rows[i]) begin
			@(posedge clk);
			fail <= 1'b1;
			lowcnt = 0;
			fcnt = 0;
			repeat (rows[i].len1) @(posedge clk);
			fail <= 1'b0;
			if (rows[i].len2 > 0) begin
				repeat (rows[i].gap) @(posedge clk);
				fail <= 1'b1;
				repeat (rows[i].len2) @(posedge clk);
				fail <= 1'b0;
			end
			repeat (100) @(posedge clk);
			cmp_int("supply reset cycles", rows[i].low, lowcnt);
			cmp_int("fault with line floating", 0, fcnt);
		end
		// Stuck line: two periods from a falling edge hold exactly 2H low
		@(posedge clk);
		flt <= 1'b0;
		wait_low(1'b0);
		@(posedge clk);
		lowcnt = 0;
		fcnt = 0;
		repeat (2 * T) @(posedge clk);
		cmp_int("repeated pulses", 2 * H, lowcnt);
		cmp_int("fault low cycles", 2 * T, fcnt);
		fail <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		cmp("fault under supply fail", 1'b1, fault_n);
		@(posedge clk);
		fail <= 1'b0;
		wait_low(1'b1);
		@(posedge clk);
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		@(posedge clk);
		#1;
		cmp("fault before service seen", 1'b0, fault_n);
		@(posedge clk);
		#1;
		cmp("fault after service", 1'b1, fault_n);
		// Service gap fits only if both edge kinds restart the count
		@(posedge clk);
		per <= 8'(T - 8);
		repeat (20) @(posedge clk);
		lowcnt = 0;
		fcnt = 0;
		repeat (4 * T) @(posedge clk);
		cmp_int("serviced resets", 0, lowcnt);
		cmp_int("serviced fault", 0, fcnt);
		per <= 8'h00;
		wait_low(1'b1);
		@(posedge clk);
		flt <= 1'b1;
		repeat (20) @(posedge clk);
		lowcnt = 0;
		fcnt = 0;
		repeat (3 * T) @(posedge clk);
		cmp_int("disabled resets", 0, lowcnt);
		cmp_int("disabled fault", 0, fcnt);
		report_and_stop();
	end
endmodule

`default_nettype wire
